// *** rtl/thermal_throttle_control.sv ***
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module thermal_throttle_control #(
  parameter int CORES = thermal_pkg::NCORES // supervised cores
) (
  input wire logic clk_sys_i, // 100 MHz system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire thermal_pkg::avs_req_t avs_req_i, // avalon-mm request
  output logic [31:0] avs_readdata_o, // avalon-mm read data
  output logic avs_waitrequest_o, // avalon-mm wait
  input wire logic [thermal_pkg::NCORES-1:0][7:0] core_delta_i, // core temp minus limit
  input wire logic catastrophic_i, // async catastrophic comparator
  input wire logic forced_throttle_n_i, // async forced throttle pin, low active
  output logic package_hot_o, // package hot, high active
  output logic catastrophic_trip_o, // catastrophic trip, high active
  output logic throttle_active_o, // throttle engine running
  output logic perf_low_o, // both cores to lowest perf state
  output logic [thermal_pkg::NCORES-1:0] core_clk_en_o, // per-core clock enable
  output logic thermal_irq_o // thermal interrupt, level
);
  localparam int N = thermal_pkg::NCORES;
  localparam logic [thermal_pkg::CNT_W-1:0] SETTLE_LIM =
    thermal_pkg::CNT_W'(thermal_pkg::PERF_SETTLE_CYC);
  localparam logic [thermal_pkg::CNT_W-1:0] DWELL_LIM =
    thermal_pkg::CNT_W'(thermal_pkg::OVER_DWELL_CYC);
  localparam logic [thermal_pkg::DIV_W-1:0] DIV_LAST =
    thermal_pkg::DIV_W'(thermal_pkg::MOD_HALF_CYC - 1);

  // the core count is fixed by the state layout
  if (CORES != thermal_pkg::NCORES) begin : g_bad_cores
    $error("core count must equal the package core count");
  end
  if (thermal_pkg::MOD_HALF_CYC > (1 << thermal_pkg::DIV_W)) begin : g_bad_div
    $error("gating divider too narrow");
  end

  // margin below the limit; at or above it reads zero, deep values saturate
  function automatic logic [thermal_pkg::RD_W-1:0] margin_of(input logic [7:0] d);
    logic [7:0] neg;
    neg = 8'h00 - d;
    if (!d[7]) begin
      return '0;
    end else if (neg[7]) begin
      return thermal_pkg::MARGIN_MAX;
    end else begin
      return neg[thermal_pkg::RD_W-1:0];
    end
  endfunction

  // saturating increment of a dwell or settle counter
  function automatic logic [thermal_pkg::CNT_W-1:0] sat_inc(
    input logic [thermal_pkg::CNT_W-1:0] v,
    input logic [thermal_pkg::CNT_W-1:0] lim
  );
    return (v >= lim) ? lim : v + thermal_pkg::CNT_W'(1);
  endfunction

  // readout register word of one core
  function automatic logic [31:0] readout_word(
    input logic [thermal_pkg::RD_W-1:0] m,
    input logic ov,
    input logic tr,
    input logic st
  );
    logic [31:0] w;
    w = '0;
    w[thermal_pkg::RD_W-1:0] = m;
    w[thermal_pkg::RB_OVER] = ov;
    w[thermal_pkg::RB_TRIP] = tr;
    w[thermal_pkg::RB_STICKY] = st;
    return w;
  endfunction

  thermal_pkg::state_t st_ff; // registered state
  thermal_pkg::state_t nxt_st; // next state

  logic en_clk; // clock-gating throttle enabled
  logic en_perf; // perf-state throttle enabled
  logic en_any; // either throttle enabled
  logic forced; // synchronised forced request, qualified
  logic hot_nx; // next hot level
  logic engine; // throttle engine request
  logic settled; // perf step has had its time
  logic req; // bus request present
  logic acc; // bus transfer completes this edge
  logic wr_ctrl; // control write
  logic wr_stat; // status clear write
  logic [7:0] clr; // status bits to clear
  logic [N-1:0] above; // core at or above limit
  logic [N-1:0] trip_nx; // next trip with hysteresis
  logic [N-1:0] mod_sel; // core selected for gating
  logic [N-1:0][thermal_pkg::RD_W-1:0] margin; // live readout margins

  assign en_clk = st_ff.ctrl[thermal_pkg::CB_CLKMOD];
  assign en_perf = st_ff.ctrl[thermal_pkg::CB_PERF];
  assign en_any = en_clk | en_perf;
  assign req = avs_req_i.read | avs_req_i.write;
  assign acc = req & st_ff.ack;
  assign wr_ctrl = acc & avs_req_i.write & avs_req_i.byteenable[0] &
                   (avs_req_i.address == thermal_pkg::OFS_CTRL);
  assign wr_stat = acc & avs_req_i.write & avs_req_i.byteenable[0] &
                   (avs_req_i.address == thermal_pkg::OFS_STAT);
  assign clr = wr_stat ? avs_req_i.writedata[7:0] : 8'h00;

  // per-core comparison against the limit, release only below the hysteresis
  for (genvar c = 0; c < N; c++) begin : g_core
    assign above[c] = ~core_delta_i[c][7];
    assign margin[c] = margin_of(core_delta_i[c]);
    assign trip_nx[c] = above[c] |
      (st_ff.trip[c] & ~($signed(core_delta_i[c]) < $signed(thermal_pkg::HYST_LOW)));
  end

  // pin is read only from the second synchroniser stage
  assign forced = ~st_ff.fsync[1] & en_any;
  assign hot_nx = |trip_nx;
  assign engine = (hot_nx & en_any) | forced;
  assign settled = (st_ff.settle == SETTLE_LIM);
  // perf first when both modes are on; gate hot cores, or all cores when forced
  assign mod_sel = {N{en_clk & engine & (~en_perf | settled)}} &
                   (trip_nx | {N{forced}});

  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // two-stage synchronisers for the asynchronous inputs
    nxt_st.fsync = {st_ff.fsync[0], forced_throttle_n_i};
    nxt_st.csync = {st_ff.csync[0], catastrophic_i};
    // catastrophic trip latches until reset and does not touch the bus
    nxt_st.cat = st_ff.cat | st_ff.csync[1];
    nxt_st.trip = trip_nx;
    // hot output comes from temperature only
    nxt_st.hot = hot_nx;
    nxt_st.engine = engine;
    nxt_st.perf_low = engine & en_perf;
    // settle timer runs while both modes throttle
    if (engine & en_perf & en_clk) begin
      nxt_st.settle = sat_inc(st_ff.settle, SETTLE_LIM);
    end else begin
      nxt_st.settle = '0;
    end
    // free-running divider, phase toggles every half period
    if (st_ff.div == DIV_LAST) begin
      nxt_st.div = '0;
      nxt_st.phase = ~st_ff.phase;
    end else begin
      nxt_st.div = st_ff.div + thermal_pkg::DIV_W'(1);
    end
    // gated cores run in the low half only; trip stops every core
    if (nxt_st.cat) begin
      nxt_st.clk_en = '0;
    end else begin
      nxt_st.clk_en = ~(mod_sel & {N{st_ff.phase}});
    end
    // over-limit: throttled core that stays hot for the dwell time
    for (int c = 0; c < N; c++) begin
      if (trip_nx[c] & engine) begin
        nxt_st.dwell[c] = sat_inc(st_ff.dwell[c], DWELL_LIM);
      end else begin
        nxt_st.dwell[c] = '0;
      end
      nxt_st.over[c] = trip_nx[c] & (st_ff.over[c] | (nxt_st.dwell[c] == DWELL_LIM));
      // setting wins over a clear in the same cycle
      nxt_st.sticky[c] = nxt_st.over[c] |
        (st_ff.sticky[c] & ~clr[thermal_pkg::SB_STICKY0 + c]);
    end
    // hot edge flags, setting wins over clearing
    nxt_st.rise = (hot_nx & ~st_ff.hot) | (st_ff.rise & ~clr[thermal_pkg::SB_RISE]);
    nxt_st.fall = (~hot_nx & st_ff.hot) | (st_ff.fall & ~clr[thermal_pkg::SB_FALL]);
    // control register write
    if (wr_ctrl) begin
      nxt_st.ctrl = avs_req_i.writedata[thermal_pkg::CTRL_W-1:0];
    end
    // interrupt from enabled flags
    nxt_st.irq = (|nxt_st.sticky & nxt_st.ctrl[thermal_pkg::CB_IE_OVER]) |
                 (nxt_st.rise & nxt_st.ctrl[thermal_pkg::CB_IE_RISE]) |
                 (nxt_st.fall & nxt_st.ctrl[thermal_pkg::CB_IE_FALL]);
    // one wait cycle per transfer
    nxt_st.ack = req & ~st_ff.ack;
    // read data captured in the wait cycle, stands through the answer cycle
    if (avs_req_i.read & ~st_ff.ack) begin
      case (avs_req_i.address)
        thermal_pkg::OFS_CORE0: begin
          nxt_st.rdata = readout_word(margin[0], st_ff.over[0], st_ff.trip[0],
                                      st_ff.sticky[0]);
        end
        thermal_pkg::OFS_CORE1: begin
          nxt_st.rdata = readout_word(margin[1], st_ff.over[1], st_ff.trip[1],
                                      st_ff.sticky[1]);
        end
        thermal_pkg::OFS_CTRL: begin
          nxt_st.rdata = {{(32 - thermal_pkg::CTRL_W){1'b0}}, st_ff.ctrl};
        end
        thermal_pkg::OFS_STAT: begin
          nxt_st.rdata = {28'h0000000, st_ff.fall, st_ff.rise, st_ff.sticky};
        end
        thermal_pkg::OFS_STATE: begin
          nxt_st.rdata = {23'h000000, st_ff.cat, ~st_ff.fsync[1], settled, st_ff.perf_low,
                          st_ff.clk_en, st_ff.phase, st_ff.hot, st_ff.engine};
        end
        default: begin
          nxt_st.rdata = 32'h00000000; // unmapped reads zero
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_ff <= thermal_pkg::ST_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flip-flops, except the bus wait
  assign avs_waitrequest_o = req & ~st_ff.ack;
  assign avs_readdata_o = st_ff.rdata;
  assign package_hot_o = st_ff.hot;
  assign catastrophic_trip_o = st_ff.cat;
  assign throttle_active_o = st_ff.engine;
  assign perf_low_o = st_ff.perf_low;
  assign core_clk_en_o = st_ff.clk_en;
  assign thermal_irq_o = st_ff.irq;

  // checks, all on the system clock
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // forced pin held low with throttling enabled for four cycles
  sequence forced_held_s;
    (!forced_throttle_n_i && en_any)[*4];
  endsequence
  // phase has just changed
  sequence phase_flip_s;
    st_ff.phase != $past(st_ff.phase);
  endsequence

  margin_sat_a: assert property (above[0] |-> margin[0] == '0)
    else $error("readout above the limit");
  hot_follow_a: assert property ((|above) |=> package_hot_o)
    else $error("hot output missed a tripped core");
  hot_cause_a: assert property (st_ff.trip == '0 |-> !package_hot_o)
    else $error("hot output without a tripped core");
  force_engine_a: assert property (forced_held_s |-> throttle_active_o)
    else $error("forced pin did not start the engine");
  hot_engine_a: assert property (package_hot_o && $past(en_any) |-> throttle_active_o)
    else $error("engine idle while hot");
  trip_hold_a: assert property (catastrophic_trip_o |=> catastrophic_trip_o)
    else $error("catastrophic trip released");
  trip_stop_a: assert property (catastrophic_trip_o |-> core_clk_en_o == '0)
    else $error("clocks running after catastrophic trip");
  perf_both_a: assert property (package_hot_o && $past(en_perf) |-> perf_low_o)
    else $error("perf step missing while hot");
  duty_half_a: assert property (phase_flip_s |=>
                                (st_ff.phase == $past(st_ff.phase))[*4] ##1 phase_flip_s)
    else $error("gating phase not half and half");
  cool_core_a: assert property (en_clk && !en_perf && !forced && !trip_nx[1] &&
                                !nxt_st.cat |=> core_clk_en_o[1])
    else $error("cool core was gated");
  perf_first_a: assert property (en_perf && !settled |-> mod_sel == '0)
    else $error("gating before perf step settled");
  sticky_keep_a: assert property (st_ff.sticky[0] && !clr[thermal_pkg::SB_STICKY0]
                                  |=> st_ff.sticky[0])
    else $error("sticky flag lost without clear");
  over_flag_a: assert property ($rose(st_ff.over[0]) |-> st_ff.sticky[0])
    else $error("over-limit without sticky flag");
  sync_delay_a: assert property ($fell(forced_throttle_n_i) && en_any
                                 |=> !forced)
    else $error("forced pin used before synchronising");

  // hot output has just risen, or just fallen
  sequence hot_up_s;
    $rose(package_hot_o);
  endsequence
  sequence hot_down_s;
    $fell(package_hot_o);
  endsequence
  // core 0 over-limit has just been latched
  sequence over_set_s;
    $rose(st_ff.over[0]);
  endsequence
  // hot core 1 sits in the gated half while only clock gating is enabled
  sequence gate_due_s;
    en_clk && !en_perf && engine && trip_nx[1] && st_ff.phase && !nxt_st.cat;
  endsequence
  // catastrophic level has just left the synchroniser
  sequence cat_seen_s;
    $rose(st_ff.csync[1]);
  endsequence
  margin_sat1_a: assert property (above[1] |-> margin[1] == '0)
    else $error("core 1 readout above the limit");
  // a tripped core stays tripped until it drops below the hysteresis floor
  trip_keep_a: assert property (st_ff.trip[0] &&
                                $signed(core_delta_i[0]) >= $signed(thermal_pkg::HYST_LOW)
                                |=> st_ff.trip[0])
    else $error("trip released inside the hysteresis band");
  trip_drop_a: assert property ($signed(core_delta_i[0]) < $signed(thermal_pkg::HYST_LOW)
                                |=> !st_ff.trip[0])
    else $error("trip held below the hysteresis floor");
  hot_cool_a: assert property (!(|above) && st_ff.trip == '0 |=> !package_hot_o)
    else $error("hot output raised with no core at the limit");
  force_run_a: assert property (forced |=> throttle_active_o)
    else $error("engine idle while the forced pin is held");
  cool_core0_a: assert property (en_clk && !en_perf && !forced && !trip_nx[0] &&
                                 !nxt_st.cat |=> core_clk_en_o[0])
    else $error("cool core 0 was gated");
  hot_gate_a: assert property (gate_due_s |=> !core_clk_en_o[1])
    else $error("hot core not gated in its off half");
  over_cause_a: assert property (over_set_s |-> st_ff.trip[0] && throttle_active_o)
    else $error("over-limit latched without throttling");
  over_irq_a: assert property ((|st_ff.sticky) && st_ff.ctrl[thermal_pkg::CB_IE_OVER]
                               |-> thermal_irq_o)
    else $error("over-limit interrupt missing");
  rise_flag_a: assert property (hot_up_s |-> st_ff.rise)
    else $error("hot rise not flagged");
  fall_flag_a: assert property (hot_down_s |-> st_ff.fall)
    else $error("hot fall not flagged");
  cat_latch_a: assert property (cat_seen_s |=> catastrophic_trip_o)
    else $error("catastrophic level not latched");
  // a transfer waits one cycle and is then answered
  wait_once_a: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus wait lasted more than one cycle");
endmodule

// *** include/thermal_pkg.sv ***
package thermal_pkg;
  // number of supervised cores
  localparam int NCORES = 2;
  // system clock period
  localparam int CLK_PERIOD_NS = 10;
  // half period of the fixed 50 % clock gating
  localparam int MOD_HALF_NS = 50;
  // time the perf-state step is given before clock gating is added
  localparam int PERF_SETTLE_NS = 10000;
  // time a throttled core may stay hot before it is flagged over limit
  localparam int OVER_DWELL_NS = 20000;
  // least hold time of the forced throttle pin, kept by the platform
  localparam int FORCE_MIN_US = 500;
  localparam int MOD_HALF_CYC = (MOD_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERF_SETTLE_CYC = (PERF_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVER_DWELL_CYC = (OVER_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 11; // dwell and settle counters
  localparam int DIV_W = 3; // gating divider
  // register byte offsets
  localparam logic [4:0] OFS_CORE0 = 5'h00;
  localparam logic [4:0] OFS_CORE1 = 5'h04;
  localparam logic [4:0] OFS_CTRL = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0C;
  localparam logic [4:0] OFS_STATE = 5'h10;
  // control register fields
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h03;
  localparam int CB_CLKMOD = 0;
  localparam int CB_PERF = 1;
  localparam int CB_IE_RISE = 2;
  localparam int CB_IE_FALL = 3;
  localparam int CB_IE_OVER = 4;
  // status register fields, write one to clear
  localparam int SB_STICKY0 = 0;
  localparam int SB_RISE = 2;
  localparam int SB_FALL = 3;
  // readout register fields
  localparam int RD_W = 7;
  localparam int RB_OVER = 8;
  localparam int RB_TRIP = 9;
  localparam int RB_STICKY = 10;
  localparam logic [RD_W-1:0] MARGIN_MAX = 7'h7F;
  // trip releases below this signed offset (hysteresis)
  localparam logic [7:0] HYST_LOW = 8'hFE;

  // avalon-mm request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

  // every flip-flop of the block
  typedef struct packed {
    logic [1:0] fsync;
    logic [1:0] csync;
    logic [NCORES-1:0] trip;
    logic [NCORES-1:0] over;
    logic [NCORES-1:0] sticky;
    logic [NCORES-1:0][CNT_W-1:0] dwell;
    logic [CNT_W-1:0] settle;
    logic [DIV_W-1:0] div;
    logic phase;
    logic hot;
    logic rise;
    logic fall;
    logic cat;
    logic engine;
    logic perf_low;
    logic [NCORES-1:0] clk_en;
    logic irq;
    logic [CTRL_W-1:0] ctrl;
    logic ack;
    logic [31:0] rdata;
  } state_t;

  localparam state_t ST_RESET = '{fsync: 2'h3, clk_en: {NCORES{1'b1}}, ctrl: CTRL_RST,
                                  default: '0};
endpackage

// *** sim/platform_model.sv ***
`timescale 1ns/100ps
// platform side: drives the forced throttle pin, watches the trip output
module platform_model #(
  parameter int HOLD_CYC = 500 // least low time of the pin, scaled down
) (
  input wire logic clk_sys_i, // system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic force_req_i, // bench asks for forced throttle
  input wire logic catastrophic_trip_i, // trip output of the device
  output logic forced_throttle_n_o, // forced throttle pin, low active
  output logic shutdown_o // platform has cut the supply
);
  int hold_ff; // cycles left of the least low time
  // pin goes low on request and never rises before the hold has run out
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      forced_throttle_n_o <= 1'b1;
      hold_ff <= 0;
    end else if (force_req_i && forced_throttle_n_o) begin
      forced_throttle_n_o <= 1'b0;
      hold_ff <= HOLD_CYC;
    end else if (hold_ff > 0) begin
      hold_ff <= hold_ff - 1;
    end else if (!force_req_i) begin
      forced_throttle_n_o <= 1'b1;
    end
  end
  // supply is cut at once when the device reports it is unsafe
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      shutdown_o <= 1'b0;
    end else if (catastrophic_trip_i) begin
      shutdown_o <= 1'b1;
    end
  end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/100ps
// self-checking bench of the thermal throttle block
module tb_top;
  logic clk_sys_i = 1'b0; // system clock
  logic reset_i = 1'b1; // synchronous reset
  thermal_pkg::avs_req_t avs_req = '0; // bus request
  logic [31:0] avs_readdata; // bus read data
  logic avs_waitrequest; // bus wait
  logic [thermal_pkg::NCORES-1:0][7:0] core_delta = {8'hF0, 8'hF0}; // both cool
  logic catastrophic = 1'b0; // catastrophic comparator
  logic forced_n; // forced pin from the platform
  logic force_req = 1'b0; // ask the platform to force
  logic package_hot_o, catastrophic_trip_o, throttle_active_o, perf_low_o, thermal_irq_o;
  logic [thermal_pkg::NCORES-1:0] core_clk_en_o; // per-core clock enable
  logic shutdown; // platform cut the supply
  logic [31:0] rd; // last read value
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  thermal_throttle_control uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .avs_req_i(avs_req), .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .core_delta_i(core_delta), .catastrophic_i(catastrophic), .forced_throttle_n_i(forced_n),
    .package_hot_o(package_hot_o), .catastrophic_trip_o(catastrophic_trip_o),
    .throttle_active_o(throttle_active_o), .perf_low_o(perf_low_o),
    .core_clk_en_o(core_clk_en_o), .thermal_irq_o(thermal_irq_o));
  platform_model #(.HOLD_CYC(500)) platform (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .force_req_i(force_req), .catastrophic_trip_i(catastrophic_trip_o),
    .forced_throttle_n_o(forced_n), .shutdown_o(shutdown));

  // 100 MHz clock
  always #5 clk_sys_i = ~clk_sys_i;

  // hang guard
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      complete_run;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one avalon-mm transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_req <= '0;
    chk(n, 2, "bus wait states");
  endtask

  task automatic rreg(input logic [4:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, what);
  endtask

  // wait for the forced pin to reach a level
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (forced_n !== lvl && n < 1000);
  endtask

  task automatic t_reset;
    chk({package_hot_o, catastrophic_trip_o, throttle_active_o, perf_low_o, core_clk_en_o,
         thermal_irq_o}, 7'h06, "outputs after reset");
    rreg(thermal_pkg::OFS_CTRL, 32'h3, "control reset");
    rreg(5'h14, 32'h0, "unmapped read");
    bus(1'b1, thermal_pkg::OFS_CORE0, 32'h7FF);
    rreg(thermal_pkg::OFS_CORE0, 32'h10, "core0 margin read only");
    core_delta[1] <= 8'h80;
    tick(2);
    rreg(thermal_pkg::OFS_CORE1, 32'h7F, "core1 margin saturates");
    core_delta[1] <= 8'hF0;
  endtask

  task automatic t_hot_perf;
    int gated;
    gated = 0;
    bus(1'b1, thermal_pkg::OFS_CTRL, 32'h3);
    core_delta[0] <= 8'h05;
    tick(4);
    chk({package_hot_o, throttle_active_o, perf_low_o, core_clk_en_o}, 5'h1F, "perf first");
    rreg(thermal_pkg::OFS_CORE0, 32'h200, "core0 at limit");
    repeat (880) begin
      @(posedge clk_sys_i);
      if (core_clk_en_o !== 2'b11) gated++;
    end
    chk(gated, 0, "no gating before settle");
    repeat (200) begin
      @(posedge clk_sys_i);
      if (core_clk_en_o[0] !== 1'b1) gated++;
    end
    chk(gated != 0, 1, "gating added after settle");
    core_delta[0] <= 8'hFE;
    tick(4);
    chk(package_hot_o, 1, "hot held inside hysteresis");
    core_delta[0] <= 8'hFD;
    tick(5);
    chk({package_hot_o, throttle_active_o, perf_low_o, core_clk_en_o}, 5'h03, "released");
  endtask

  task automatic t_gating_only;
    int z0;
    int z1;
    z0 = 0;
    z1 = 0;
    bus(1'b1, thermal_pkg::OFS_CTRL, 32'h1);
    core_delta[1] <= 8'h00;
    tick(4);
    repeat (40) begin
      @(posedge clk_sys_i);
      if (core_clk_en_o[0] !== 1'b1) z0++;
      if (core_clk_en_o[1] !== 1'b0) z1++;
    end
    chk(z1, 20, "hot core half gated");
    chk({z0[7:0], package_hot_o, perf_low_o}, 10'h2, "cool core runs");
    core_delta[1] <= 8'hF0;
    tick(5);
    chk({package_hot_o, throttle_active_o, core_clk_en_o}, 4'h3, "gating ends");
  endtask

  task automatic t_forced;
    force_req <= 1'b1;
    wait_pin(1'b0);
    tick(1);
    chk(throttle_active_o, 0, "forced pin synchronised");
    tick(2);
    chk({throttle_active_o, package_hot_o}, 2'h2, "forced engine, no hot");
    bus(1'b0, thermal_pkg::OFS_STATE, 32'h0);
    chk({rd[8:5], rd[1:0]}, 6'h11, "forced seen in state");
    force_req <= 1'b0;
    wait_pin(1'b1);
    tick(1);
    chk(throttle_active_o, 1, "engine held until sync");
    tick(2);
    chk(throttle_active_o, 0, "engine ends with pin");
  endtask

  task automatic t_over_limit;
    bus(1'b1, thermal_pkg::OFS_CTRL, 32'h13);
    core_delta[0] <= 8'h00;
    tick(2030);
    rreg(thermal_pkg::OFS_CORE0, 32'h700, "over and sticky");
    chk(thermal_irq_o, 1, "over-limit interrupt");
    core_delta[0] <= 8'hF0;
    tick(5);
    rreg(thermal_pkg::OFS_CORE0, 32'h410, "sticky held");
    bus(1'b1, thermal_pkg::OFS_STAT, 32'hF);
    tick(2);
    rreg(thermal_pkg::OFS_CORE0, 32'h10, "sticky cleared");
    chk(thermal_irq_o, 0, "interrupt cleared");
  endtask

  task automatic t_hot_irq;
    bus(1'b1, thermal_pkg::OFS_CTRL, 32'h7);
    core_delta[1] <= 8'h00;
    tick(4);
    chk(thermal_irq_o, 1, "irq on hot rise");
    bus(1'b0, thermal_pkg::OFS_STAT, 32'h0);
    chk(rd[3:0], 4'h4, "rise flag");
    bus(1'b1, thermal_pkg::OFS_STAT, 32'h4);
    bus(1'b1, thermal_pkg::OFS_CTRL, 32'hB);
    rreg(thermal_pkg::OFS_CTRL, 32'hB, "control readback");
    tick(2);
    chk(thermal_irq_o, 0, "rise flag cleared");
    core_delta[1] <= 8'hF0;
    tick(4);
    chk(thermal_irq_o, 1, "irq on hot fall");
    bus(1'b1, thermal_pkg::OFS_STAT, 32'h8);
    tick(2);
    chk(thermal_irq_o, 0, "fall flag cleared");
  endtask

  task automatic t_catastrophic;
    catastrophic <= 1'b1;
    tick(2);
    catastrophic <= 1'b0;
    tick(20);
    chk({catastrophic_trip_o, shutdown}, 2'h3, "trip latched without bus");
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // main sequence
  initial begin
    tick(10);
    reset_i <= 1'b0;
    tick(1);
    t_reset;
    t_hot_perf;
    t_gating_only;
    t_forced;
    t_over_limit;
    t_hot_irq;
    t_catastrophic;
    complete_run;
  end
endmodule
